//--- common/osr_pkg.sv
// constants and types shared by the slew and range control block
`default_nettype none
package osr_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CODE_W = 16;
   localparam int FRAC_W = 4;
   localparam int ACC_W = CODE_W + FRAC_W;
   typedef logic [ACC_W-1:0] osr_acc_t;

   // register port offsets
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h01;
   localparam logic [7:0] ADDR_CONTROL = 8'h02;
   localparam logic [7:0] ADDR_GAIN = 8'h03;
   localparam logic [7:0] ADDR_ZERO = 8'h04;

   // control and status fields
   localparam int CTL_RANGE_LSB = 0;
   localparam int CTL_RANGE_W = 3;
   localparam int CTL_SLEW_EN_BIT = 4;
   localparam int CTL_STEP_LSB = 5;
   localparam int CTL_STEP_W = 3;
   localparam int CTL_RATE_LSB = 8;
   localparam int CTL_RATE_W = 4;
   localparam int CTL_CAL_EN_BIT = 12;
   localparam logic [15:0] CTL_WR_MASK = 16'h1FF7;
   localparam int STS_RAMP_BIT = 1;

   // reset values
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [15:0] GAIN_RST = 16'h0000;
   localparam logic [15:0] ZERO_RST = 16'h0000;
   localparam osr_acc_t ACC_RST = 20'h00000;

   // code limits and calibration offset
   localparam logic [15:0] CODE16_MAX = 16'hFFFF;
   localparam logic [15:0] CODE12_MAX = 16'h0FFF;
   localparam logic [16:0] GAIN_OFFSET = 17'h08000;

   // output range codes
   localparam logic [2:0] RANGE_4_20 = 3'h5;
   localparam logic [2:0] RANGE_0_20 = 3'h6;
   localparam logic [2:0] RANGE_0_24 = 3'h7;
   typedef enum logic [1:0] {
      OSR_RANGE_OFF,
      OSR_RANGE_4_20,
      OSR_RANGE_0_20,
      OSR_RANGE_0_24
   } osr_range_t;

   // step sizes of the 12-bit variant in sixteenths of a code unit
   localparam logic [7:0] STEP12_SIXTEENTHS [8] = '{
      8'h01, 8'h02, 8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

   // update tick frequencies in Hz
   localparam int RATE_HZ [16] = '{
      258065, 200000, 153845, 131145, 115940, 69565, 37560, 25805,
      20150, 16030, 10295, 8280, 6900, 5530, 4240, 3300};
endpackage
`default_nettype wire

//--- design/osr_tick_gen.sv
// update tick generator for the digital slew
`timescale 1ns/1ns
`default_nettype none
module osr_tick_gen #(
   parameter int CLK_HZ = osr_pkg::CLK_HZ
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] rate_sel_i,
   input wire logic restart_i,
   output logic tick_o
);
   logic [23:0] cnt_reg;
   logic [23:0] period;

   // cycles per tick, rounded down, never below one
   function automatic logic [23:0] tick_period(input logic [3:0] sel);
      int p;
      p = CLK_HZ / osr_pkg::RATE_HZ[sel];
      if (p < 1) begin
         p = 1;
      end
      return 24'(p);
   endfunction

   assign period = tick_period(rate_sel_i);

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_reg <= 24'h000000;
         tick_o <= 1'b0;
      end else if (restart_i) begin
         cnt_reg <= 24'h000000;
         tick_o <= 1'b0;
      end else if (cnt_reg >= period - 24'h000001) begin
         cnt_reg <= 24'h000000;
         tick_o <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 24'h000001;
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- design/osr_stepper.sv
// one slew step toward the target, clamped so it never overshoots
`timescale 1ns/1ns
`default_nettype none
module osr_stepper (
   input wire osr_pkg::osr_acc_t cur_i,
   input wire osr_pkg::osr_acc_t tgt_i,
   input wire osr_pkg::osr_acc_t step_i,
   output osr_pkg::osr_acc_t nxt_o
);
   osr_pkg::osr_acc_t diff;

   always_comb begin
      diff = osr_pkg::ACC_RST;
      nxt_o = cur_i;
      if (tgt_i > cur_i) begin
         diff = tgt_i - cur_i;
         nxt_o = (diff <= step_i) ? tgt_i : cur_i + step_i;
      end else if (tgt_i < cur_i) begin
         diff = cur_i - tgt_i;
         nxt_o = (diff <= step_i) ? tgt_i : cur_i - step_i;
      end
   end
endmodule
`default_nettype wire

//--- design/osr_top.sv
// slew-rate limiter and output range control of a current-output converter
// Summary of operation
// - slew off: a written data code reaches the converter at once
// - control bit 4 turns digital slew limiting on or off
// - control bits 7:5 select the step size
// - control bits 11:8 select the update tick rate
// - slew on: applied code moves one step per tick toward target
// - 16-bit variant steps are 1,2,4,...,128 code units
// - 12-bit variant steps 1/16 to 8 units, kept with fractional bits
// - rate selections give sixteen tick frequencies, 258065 Hz down to 3300 Hz
// - reading the data register returns the applied code, not target
// - slew on: every change of the applied code is stepped
// - force-zero input with slew on ramps the code to zero
// - status bit 1 shows that a ramp is in progress
// - tick frequency does not depend on the output range
// - range 101 is 4-20 mA, 110 is 0-20 mA, 111 is 0-24 mA
// - a write changing the range field clears the data register
// - calibration changes act only on later data writes
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module osr_top #(
   parameter int CLK_HZ = osr_pkg::CLK_HZ,
   parameter bit IS_12BIT = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   input wire logic force_zero_input_i,
   output logic [15:0] dac_code_o,
   output logic ramp_active_flag_o,
   output osr_pkg::osr_range_t current_output_range_o,
   output logic current_output_en_o
);
   logic [15:0] control_reg;
   logic [15:0] gain_reg;
   logic [15:0] zero_reg;
   logic [15:0] rdata_reg;
   osr_pkg::osr_acc_t target_reg;
   osr_pkg::osr_acc_t applied_reg;
   osr_pkg::osr_acc_t eff_tgt;
   osr_pkg::osr_acc_t step_acc;
   osr_pkg::osr_acc_t step_nxt;
   logic fz_meta_reg;
   logic fz_sync_reg;
   logic slew_en;
   logic cal_en;
   logic tick;
   logic ramping;
   logic [2:0] step_sel;
   logic [3:0] rate_sel;
   logic [2:0] range_sel;
   logic wr_data;
   logic wr_ctl;
   logic range_change;
   logic [15:0] code_mask;
   logic [15:0] wr_code;
   logic [15:0] cal_code;
   logic [32:0] cal_prod;
   logic signed [18:0] cal_sum;

   // control field decode
   assign slew_en = control_reg[osr_pkg::CTL_SLEW_EN_BIT];
   assign step_sel = control_reg[osr_pkg::CTL_STEP_LSB +: osr_pkg::CTL_STEP_W];
   assign rate_sel = control_reg[osr_pkg::CTL_RATE_LSB +: osr_pkg::CTL_RATE_W];
   assign range_sel = control_reg[osr_pkg::CTL_RANGE_LSB +: osr_pkg::CTL_RANGE_W];
   assign cal_en = control_reg[osr_pkg::CTL_CAL_EN_BIT];
   assign code_mask = IS_12BIT ? osr_pkg::CODE12_MAX : osr_pkg::CODE16_MAX;

   // write decode
   always_comb begin
      wr_data = 1'b0;
      wr_ctl = 1'b0;
      if (reg_wr_i && reg_addr_i == osr_pkg::ADDR_DATA) begin
         wr_data = 1'b1;
      end else if (reg_wr_i && reg_addr_i == osr_pkg::ADDR_CONTROL) begin
         wr_ctl = 1'b1;
      end
   end

   assign range_change = wr_ctl &&
      (reg_wdata_i[osr_pkg::CTL_RANGE_LSB +: osr_pkg::CTL_RANGE_W] != range_sel);

   // configuration registers; the reserved bit 3 and bits above 12 read zero
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         control_reg <= osr_pkg::CONTROL_RST;
      end else if (wr_ctl) begin
         control_reg <= reg_wdata_i & osr_pkg::CTL_WR_MASK;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gain_reg <= osr_pkg::GAIN_RST;
         zero_reg <= osr_pkg::ZERO_RST;
      end else if (reg_wr_i && reg_addr_i == osr_pkg::ADDR_GAIN) begin
         gain_reg <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == osr_pkg::ADDR_ZERO) begin
         zero_reg <= reg_wdata_i;
      end
   end

   // calibration is applied only to the word being written now
   always_comb begin
      wr_code = reg_wdata_i & code_mask;
      cal_prod = 33'(wr_code) * 33'({1'b0, gain_reg} + osr_pkg::GAIN_OFFSET);
      cal_sum = $signed({2'b00, cal_prod[32:16]}) + $signed({{3{zero_reg[15]}}, zero_reg});
      if (!cal_en) begin
         cal_code = wr_code;
      end else if (cal_sum < 0) begin
         cal_code = 16'h0000;
      end else if (cal_sum > $signed({3'b000, code_mask})) begin
         cal_code = code_mask;
      end else begin
         cal_code = cal_sum[15:0];
      end
   end

   // target code; gain and zero writes leave it alone
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         target_reg <= osr_pkg::ACC_RST;
      end else if (range_change) begin
         target_reg <= osr_pkg::ACC_RST;
      end else if (wr_data) begin
         target_reg <= {cal_code, {osr_pkg::FRAC_W{1'b0}}};
      end
   end

   // force-zero pin comes from outside the clock domain
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fz_meta_reg <= 1'b0;
         fz_sync_reg <= 1'b0;
      end else begin
         fz_meta_reg <= force_zero_input_i;
         fz_sync_reg <= fz_meta_reg;
      end
   end

   // the pin overrides the target without touching the stored data word
   assign eff_tgt = fz_sync_reg ? osr_pkg::ACC_RST : target_reg;

   // step size in sixteenths of a code unit
   always_comb begin
      if (IS_12BIT) begin
         step_acc = osr_pkg::osr_acc_t'(osr_pkg::STEP12_SIXTEENTHS[step_sel]);
      end else begin
         step_acc = osr_pkg::osr_acc_t'(1) << (osr_pkg::FRAC_W + int'(step_sel));
      end
   end

   assign ramping = slew_en && (applied_reg != eff_tgt);
   assign ramp_active_flag_o = ramping;

   // the tick counter restarts when idle, so a fresh ramp gets a full first period
   osr_tick_gen #(
      .CLK_HZ(CLK_HZ)
   ) u_tick (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .rate_sel_i(rate_sel),
      .restart_i(!ramping),
      .tick_o(tick)
   );

   // always steps from the present applied code, so a new target redirects
   osr_stepper u_step (
      .cur_i(applied_reg),
      .tgt_i(eff_tgt),
      .step_i(step_acc),
      .nxt_o(step_nxt)
   );

   // applied code
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         applied_reg <= osr_pkg::ACC_RST;
      end else if (!slew_en) begin
         applied_reg <= eff_tgt;
      end else if (tick) begin
         applied_reg <= step_nxt;
      end
   end

   assign dac_code_o = applied_reg[osr_pkg::FRAC_W +: osr_pkg::CODE_W];

   // range decode; unlisted codes leave the output disabled
   always_comb begin
      current_output_range_o = osr_pkg::OSR_RANGE_OFF;
      current_output_en_o = 1'b1;
      case (range_sel)
         osr_pkg::RANGE_4_20: current_output_range_o = osr_pkg::OSR_RANGE_4_20;
         osr_pkg::RANGE_0_20: current_output_range_o = osr_pkg::OSR_RANGE_0_20;
         osr_pkg::RANGE_0_24: current_output_range_o = osr_pkg::OSR_RANGE_0_24;
         default: current_output_en_o = 1'b0;
      endcase
   end

   // read data stands for exactly one cycle after the strobe
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 16'h0000;
      end else if (!reg_rd_i) begin
         rdata_reg <= 16'h0000;
      end else if (reg_addr_i == osr_pkg::ADDR_STATUS) begin
         rdata_reg <= 16'(ramping) << osr_pkg::STS_RAMP_BIT;
      end else if (reg_addr_i == osr_pkg::ADDR_DATA) begin
         rdata_reg <= dac_code_o;
      end else if (reg_addr_i == osr_pkg::ADDR_CONTROL) begin
         rdata_reg <= control_reg;
      end else if (reg_addr_i == osr_pkg::ADDR_GAIN) begin
         rdata_reg <= gain_reg;
      end else if (reg_addr_i == osr_pkg::ADDR_ZERO) begin
         rdata_reg <= zero_reg;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   assign reg_rdata_o = rdata_reg;

   // helper for the tick spacing checks: cycles since the last tick of an unbroken ramp
   logic [23:0] tick_gap_reg;
   logic [23:0] tick_per;

   assign tick_per = (CLK_HZ / osr_pkg::RATE_HZ[rate_sel] < 1) ? 24'h000001 :
      24'(CLK_HZ / osr_pkg::RATE_HZ[rate_sel]);

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_gap_reg <= 24'h000001;
      end else if (tick || !ramping) begin
         tick_gap_reg <= 24'h000001;
      end else begin
         tick_gap_reg <= tick_gap_reg + 24'h000001;
      end
   end

   // checks on the design's own behaviour
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_tick_up;
      slew_en && tick && (eff_tgt > applied_reg);
   endsequence

   sequence s_tick_down;
      slew_en && tick && (eff_tgt < applied_reg);
   endsequence

   sequence s_gain_write;
      reg_wr_i && (reg_addr_i == osr_pkg::ADDR_GAIN || reg_addr_i == osr_pkg::ADDR_ZERO);
   endsequence

   property p_direct_apply;
      !slew_en |=> applied_reg == $past(eff_tgt);
   endproperty
   a_direct_apply: assert property (p_direct_apply)
      else $error("applied code did not follow target with slew off");

   property p_hold_between_ticks;
      slew_en && !tick |=> $stable(applied_reg);
   endproperty
   a_hold_between_ticks: assert property (p_hold_between_ticks)
      else $error("applied code moved without a tick");

   property p_full_step_up;
      s_tick_up and (eff_tgt - applied_reg > step_acc)
         |=> applied_reg == $past(applied_reg) + $past(step_acc);
   endproperty
   a_full_step_up: assert property (p_full_step_up)
      else $error("upward step differs from the selected size");

   property p_full_step_down;
      s_tick_down and (applied_reg - eff_tgt > step_acc)
         |=> applied_reg == $past(applied_reg) - $past(step_acc);
   endproperty
   a_full_step_down: assert property (p_full_step_down)
      else $error("downward step differs from the selected size");

   property p_land_on_target;
      slew_en && tick && (eff_tgt != applied_reg) &&
         ((eff_tgt > applied_reg ? eff_tgt - applied_reg : applied_reg - eff_tgt) <= step_acc)
         |=> applied_reg == $past(eff_tgt);
   endproperty
   a_land_on_target: assert property (p_land_on_target)
      else $error("last step did not land on the target");

   property p_status_read;
      reg_rd_i && reg_addr_i == osr_pkg::ADDR_STATUS
         |=> reg_rdata_o[osr_pkg::STS_RAMP_BIT] == $past(ramp_active_flag_o);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read did not show the ramp flag");

   property p_data_read;
      reg_rd_i && reg_addr_i == osr_pkg::ADDR_DATA |=> reg_rdata_o == $past(dac_code_o);
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read did not return the applied code");

   property p_range_clear;
      range_change |=> target_reg == osr_pkg::ACC_RST;
   endproperty
   a_range_clear: assert property (p_range_clear)
      else $error("range change did not clear the data register");

   property p_zero_ramp;
      fz_sync_reg && slew_en && tick && applied_reg != osr_pkg::ACC_RST
         |=> applied_reg < $past(applied_reg);
   endproperty
   a_zero_ramp: assert property (p_zero_ramp)
      else $error("force-zero did not ramp the code down");

   property p_cal_no_effect;
      s_gain_write |=> $stable(target_reg);
   endproperty
   a_cal_no_effect: assert property (p_cal_no_effect)
      else $error("calibration write changed the target");

   property p_tick_spacing;
      tick && ramping |-> tick_gap_reg >= tick_per;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing)
      else $error("update ticks came closer than the selected rate");

   property p_tick_due;
      ramping && !tick |-> tick_gap_reg <= tick_per;
   endproperty
   a_tick_due: assert property (p_tick_due)
      else $error("update tick overdue for the selected rate");

   property p_first_step_wait;
      $rose(ramping) |-> !tick;
   endproperty
   a_first_step_wait: assert property (p_first_step_wait)
      else $error("a fresh ramp stepped without a full tick period");

   property p_flag_off;
      !slew_en |-> !ramp_active_flag_o;
   endproperty
   a_flag_off: assert property (p_flag_off)
      else $error("ramp flag high with slew limiting off");
endmodule
`default_nettype wire

//--- dv/osr_host_model.sv
// host processor model: master of the register port
`timescale 1ns/1ns
`default_nettype none
module osr_host_model (
   input wire logic sys_clk_i,
   output logic [7:0] reg_addr_o,
   output logic [15:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [15:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 16'h0000;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end

   // address and data word go out together in one strobe cycle
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      // scrambled so the design cannot lean on stale write data
      reg_wdata_o <= ~d;
      // return inside the cycle, so callers never read outputs in the edge's own time step
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      #1;
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

//--- dv/osr_top_test.sv
// self-checking testbench of the slew and range control block
`timescale 1ns/1ns
`default_nettype none
module osr_top_test;
   // slowest rate selection then ticks every 4 cycles
   localparam int CLK_HZ = 13200;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic force_zero_input_i = 1'b0;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [15:0] dac16;
   logic [15:0] dac12;
   logic ramp_active_flag_o;
   osr_pkg::osr_range_t current_output_range_o;
   logic current_output_en_o;
   int n_fail = 0;
   int total_checks = 0;

   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   osr_host_model i_osr_host_model (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr),
      .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
   osr_top #(.CLK_HZ(CLK_HZ), .IS_12BIT(1'b0)) i_osr_top (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .force_zero_input_i(force_zero_input_i),
      .dac_code_o(dac16), .ramp_active_flag_o(ramp_active_flag_o),
      .current_output_range_o(current_output_range_o), .current_output_en_o(current_output_en_o));
   osr_top #(.CLK_HZ(CLK_HZ), .IS_12BIT(1'b1)) i_osr_top12 (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(), .force_zero_input_i(force_zero_input_i),
      .dac_code_o(dac12), .ramp_active_flag_o(), .current_output_range_o(),
      .current_output_en_o());

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [15:0] ctl(input int rng, input int en, input int st, input int rt);
      return {4'h0, rt[3:0], st[2:0], en[0], 1'b0, rng[2:0]};
   endfunction

   function automatic logic [15:0] code(input bit w);
      return w ? dac12 : dac16;
   endfunction

   function automatic int per_of(input int rt);
      return (CLK_HZ / osr_pkg::RATE_HZ[rt] < 1) ? 1 : CLK_HZ / osr_pkg::RATE_HZ[rt];
   endfunction

   task automatic wait_change(input bit w, output int n);
      logic [15:0] c;
      c = code(w);
      n = 0;
      do begin
         @(posedge sys_clk_i);
         #1;
         n++;
         if (n > 3000) begin
            n_fail++;
            finish_test();
         end
      end while (code(w) === c);
   endtask

   // s16 is the step in sixteenths of a unit, p the tick period in cycles
   task automatic ramp(input bit w, input logic [15:0] tgt, input int s16, input int p);
      int n;
      int inc;
      int per;
      int k;
      logic [15:0] e;
      inc = (s16 < 16) ? 1 : s16 / 16;
      per = (s16 < 16) ? p * 16 / s16 : p;
      k = 0;
      if (!w && code(0) !== tgt) chk(16'(ramp_active_flag_o), 16'h0001);
      while (code(w) !== tgt) begin
         e = (code(w) < tgt) ? ((tgt - code(w) > inc) ? code(w) + 16'(inc) : tgt)
            : ((code(w) - tgt > inc) ? code(w) - 16'(inc) : tgt);
         wait_change(w, n);
         chk(code(w), e);
         // the first step also holds the tick restart, so only later gaps are timed
         if (k > 0) chk(16'(n), 16'(per));
         k++;
      end
      if (!w) chk(16'(ramp_active_flag_o), 16'h0000);
   endtask

   // slew settings always go in before the new data word
   task automatic go(input logic [15:0] c, input logic [15:0] tgt);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_CONTROL, c & 16'hFFEF);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, 16'h0000);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_CONTROL, c);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, tgt);
   endtask

   initial begin
      logic [15:0] d;
      int n;
      repeat (8) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      #1;
      chk(dac16, 16'h0000);
      chk(16'(ramp_active_flag_o), 16'h0000);
      chk(16'(current_output_range_o), 16'h0000);
      chk(16'(current_output_en_o), 16'h0000);
      for (int r = 1; r < 8; r++) begin
         i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, 16'h55AA);
         i_osr_host_model.wr_reg(osr_pkg::ADDR_CONTROL, ctl(r, 0, 0, 0));
         i_osr_host_model.rd_reg(osr_pkg::ADDR_DATA, d);
         chk(d, 16'h0000);
         chk(dac16, 16'h0000);
         chk(16'(current_output_range_o), (r < 5) ? 16'h0000 : 16'(r - 4));
         chk(16'(current_output_en_o), 16'(r >= 5));
      end
      i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, 16'h1234);
      @(posedge sys_clk_i);
      #1;
      chk(dac16, 16'h1234);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_CONTROL, ctl(7, 0, 0, 0) | 16'h1000);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_GAIN, 16'hFFFF);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_ZERO, 16'h0100);
      i_osr_host_model.wr_reg(8'h20, 16'h0F0F);
      i_osr_host_model.rd_reg(8'h20, d);
      chk(d, 16'h0000);
      i_osr_host_model.rd_reg(osr_pkg::ADDR_DATA, d);
      chk(d, 16'h1234);
      chk(dac16, 16'h1234);
      // the next data word is calibrated: 0x1234 * 0x17FFF >> 16, plus zero 0x100
      i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, 16'h1234);
      @(posedge sys_clk_i);
      #1;
      chk(dac16, 16'h1C4D);
      for (int s = 0; s < 8; s++) begin
         go(ctl(5, 1, s, 15), 16'(3 * (1 << s) - 1));
         ramp(0, 16'(3 * (1 << s) - 1), 16 << s, 4);
      end
      for (int r = 0; r < 16; r++) begin
         go(ctl(5 + r % 3, 1, 7, r), 16'h0180);
         ramp(0, 16'h0180, 2048, per_of(r));
      end
      for (int s = 0; s < 8; s++) begin
         go(ctl(5, 1, s, 15), 16'h0003);
         ramp(1, 16'h0003, int'(osr_pkg::STEP12_SIXTEENTHS[s]), 4);
      end
      go(ctl(5, 1, 0, 15), 16'd100);
      i_osr_host_model.rd_reg(osr_pkg::ADDR_STATUS, d);
      chk(d & 16'h0002, 16'h0002);
      wait_change(0, n);
      i_osr_host_model.rd_reg(osr_pkg::ADDR_DATA, d);
      chk(d, 16'h0001);
      wait_change(0, n);
      i_osr_host_model.wr_reg(osr_pkg::ADDR_DATA, 16'h0000);
      ramp(0, 16'h0000, 16, 4);
      i_osr_host_model.rd_reg(osr_pkg::ADDR_STATUS, d);
      chk(d & 16'h0002, 16'h0000);
      go(ctl(5, 1, 0, 15), 16'h0003);
      ramp(0, 16'h0003, 16, 4);
      @(posedge sys_clk_i);
      force_zero_input_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      #1;
      ramp(0, 16'h0000, 16, 4);
      @(posedge sys_clk_i);
      force_zero_input_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1;
      ramp(0, 16'h0003, 16, 4);
      finish_test();
   end
endmodule
`default_nettype wire
